// *** hdl/lvs_params.svh ***
`ifndef LVS_PARAMS_SVH
`define LVS_PARAMS_SVH
`define LVS_ROW_CHARS 5'd16
`define LVS_CMD_MAX 3'd5
`define LVS_CONV_LAST 6'd39
`define LVS_MAX_CHANNEL 7'd63
`define LVS_NV_BITS 17
`define LVS_COL_VALUE 4'd5
`define LVS_COL_POINT 4'd12
`define LVS_COL_LAST 4'd15
`define LVS_ASC_CR 8'h0d
`define LVS_ASC_LF 8'h0a
`define LVS_ASC_ZERO 8'h30
`define LVS_ASC_SPACE 8'h20
`define LVS_ASC_POINT 8'h2e
`define LVS_TXT_UPPER 24'h534455
`define LVS_TXT_LOWER 24'h53444c
`define LVS_TXT_TM 16'h544d
`define LVS_TXT_CP 16'h4350
`define LVS_TXT_TP 16'h5450
`define LVS_TXT_LIGHT_ON 32'h424b4f4e
`define LVS_TXT_LIGHT_OFF 40'h424b4f4646
`define LVS_LBL_COUNT 24'h434e54
`define LVS_LBL_TIMER 40'h54494d4552
`define LVS_LBL_PCOUNT 40'h434e545052
`define LVS_LBL_TPRESET 40'h54494d5052
`define LVS_RST_BACKLIGHT 1'b1
`define LVS_RST_UPPER_CH 6'h00
`define LVS_RST_LOWER_CH 6'h00
`endif

// *** hdl/lvs_pkg.sv ***
package lvs_pkg;
    typedef enum logic [1:0] {SRC_COUNT, SRC_TIMER, SRC_PCOUNT, SRC_TPRESET} lvs_src_t;
    typedef enum logic [2:0] {ST_SETUP, ST_LATCH, ST_CONVERT, ST_EMIT} lvs_state_t;
endpackage

// *** hdl/lvs_lcd_view_select.sv ***
// Behaviour
// - two rows of sixteen characters, switchable backlight
// - render 32-bit counts and 40-bit timer values
// - each row shows one of four sources
// - upper-row command selects channel, timer or presets
// - lower-row command selects channel, timer or presets
// - backlight on and off commands
// - selections and backlight saved, restored after power-up
`timescale 1ns/1ps
`default_nettype none
`include "lvs_params.svh"
module lvs_lcd_view_select
    import lvs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic [7:0] cmdByte,
    output logic cmdReady,
    output logic cmdDone,
    output logic cmdBad,
    output logic nvLoadReq,
    input wire logic nvLoadDone,
    input wire logic [`LVS_NV_BITS-1:0] nvLoadData,
    output logic nvStore,
    output logic [`LVS_NV_BITS-1:0] nvStoreData,
    output logic [5:0] chanAddr,
    input wire logic [31:0] countValue,
    input wire logic [31:0] presetCount,
    input wire logic [39:0] timerValue,
    input wire logic [39:0] timerPreset,
    output logic charValid,
    input wire logic charReady,
    output logic charRow,
    output logic [3:0] charCol,
    output logic [7:0] charCode,
    output logic backlightOn
);

    function automatic logic isDigit(input logic [7:0] c);
        isDigit = (c >= `LVS_ASC_ZERO) && (c <= `LVS_ASC_ZERO + 8'h09);
    endfunction

    // add three to every bcd nibble above four
    function automatic logic [51:0] dabble(input logic [51:0] bcd);
        logic [51:0] r;
        r = bcd;
        for (int i = 0; i < 13; i++) begin
            if (r[i*4 +: 4] > 4'h4) begin
                r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
            end
        end
        dabble = r;
    endfunction

    function automatic logic [7:0] charAt(input logic [3:0] col, input lvs_src_t src,
                                          input logic [5:0] ch, input logic [51:0] bcd);
        logic [39:0] label;
        logic isTime;
        int idx;
        logic [51:0] sh;
        isTime = (src == SRC_TIMER) || (src == SRC_TPRESET);
        case (src)
            SRC_COUNT: label = {`LVS_LBL_COUNT, `LVS_ASC_ZERO + {2'h0, ch / 6'd10},
                                `LVS_ASC_ZERO + {2'h0, ch % 6'd10}};
            SRC_TIMER: label = `LVS_LBL_TIMER;
            SRC_PCOUNT: label = `LVS_LBL_PCOUNT;
            default: label = `LVS_LBL_TPRESET;
        endcase
        // timer is in microseconds: drop four digits, keep hundredths
        if (isTime) begin
            idx = (col > `LVS_COL_POINT) ? 18 - int'(col) : 17 - int'(col);
        end else begin
            idx = 14 - int'(col);
        end
        sh = bcd >> (idx * 4);
        if (col < `LVS_COL_VALUE) begin
            charAt = label[39 - 8 * int'(col) -: 8];
        end else if (col == `LVS_COL_LAST) begin
            charAt = `LVS_ASC_SPACE;
        end else if (isTime && col == `LVS_COL_POINT) begin
            charAt = `LVS_ASC_POINT;
        end else begin
            charAt = `LVS_ASC_ZERO + {4'h0, sh[3:0]};
        end
    endfunction

    // command parser and saved settings
    logic [7:0] buf_reg [`LVS_CMD_MAX];
    logic [7:0] buf_next [`LVS_CMD_MAX];
    logic [2:0] len_reg, len_next;
    logic ovf_reg, ovf_next;
    logic restore_reg, restore_next;
    lvs_src_t upSrc_reg, upSrc_next, lowSrc_reg, lowSrc_next;
    logic [5:0] upCh_reg, upCh_next, lowCh_reg, lowCh_next;
    logic light_reg, light_next;
    logic done_reg, done_next, bad_reg, bad_next, store_reg, store_next;

    always_comb begin
        logic hit, upper, lower;
        logic [1:0] loadLow, loadUp;
        logic [6:0] ch;
        lvs_src_t src;
        hit = 1'b0;
        loadLow = 2'h0;
        loadUp = 2'h0;
        upper = 1'b0;
        lower = 1'b0;
        ch = 7'h00;
        src = SRC_COUNT;
        buf_next = buf_reg;
        len_next = len_reg;
        ovf_next = ovf_reg;
        restore_next = restore_reg;
        upSrc_next = upSrc_reg;
        upCh_next = upCh_reg;
        lowSrc_next = lowSrc_reg;
        lowCh_next = lowCh_reg;
        light_next = light_reg;
        done_next = 1'b0;
        bad_next = 1'b0;
        store_next = 1'b0;
        if (restore_reg) begin
            if (nvLoadDone) begin
                {light_next, loadLow, lowCh_next, loadUp, upCh_next} = nvLoadData;
                lowSrc_next = lvs_src_t'(loadLow);
                upSrc_next = lvs_src_t'(loadUp);
                restore_next = 1'b0;
            end
        end else if (cmdValid) begin
            if (cmdByte == `LVS_ASC_CR || cmdByte == `LVS_ASC_LF) begin
                len_next = 3'h0;
                ovf_next = 1'b0;
                if (len_reg != 3'h0) begin
                    upper = {buf_reg[0], buf_reg[1], buf_reg[2]} == `LVS_TXT_UPPER;
                    lower = {buf_reg[0], buf_reg[1], buf_reg[2]} == `LVS_TXT_LOWER;
                    ch = {3'h0, buf_reg[3][3:0]} * 7'd10 + {3'h0, buf_reg[4][3:0]};
                    if (!ovf_reg && len_reg == `LVS_CMD_MAX && (upper || lower)) begin
                        hit = 1'b1;
                        if (isDigit(buf_reg[3]) && isDigit(buf_reg[4]) && ch <= `LVS_MAX_CHANNEL) begin
                            src = SRC_COUNT;
                        end else if ({buf_reg[3], buf_reg[4]} == `LVS_TXT_TM) begin
                            src = SRC_TIMER;
                        end else if ({buf_reg[3], buf_reg[4]} == `LVS_TXT_CP) begin
                            src = SRC_PCOUNT;
                        end else if ({buf_reg[3], buf_reg[4]} == `LVS_TXT_TP) begin
                            src = SRC_TPRESET;
                        end else begin
                            hit = 1'b0;
                        end
                        if (hit && upper) begin
                            upSrc_next = src;
                            if (src == SRC_COUNT) begin
                                upCh_next = ch[5:0];
                            end
                        end
                        if (hit && lower) begin
                            lowSrc_next = src;
                            if (src == SRC_COUNT) begin
                                lowCh_next = ch[5:0];
                            end
                        end
                    end else if (!ovf_reg && len_reg == 3'd4 &&
                                 {buf_reg[0], buf_reg[1], buf_reg[2], buf_reg[3]} == `LVS_TXT_LIGHT_ON) begin
                        hit = 1'b1;
                        light_next = 1'b1;
                    end else if (!ovf_reg && len_reg == `LVS_CMD_MAX &&
                                 {buf_reg[0], buf_reg[1], buf_reg[2], buf_reg[3], buf_reg[4]}
                                 == `LVS_TXT_LIGHT_OFF) begin
                        hit = 1'b1;
                        light_next = 1'b0;
                    end
                    done_next = hit;
                    bad_next = !hit;
                    store_next = hit;
                end
            end else if (len_reg == `LVS_CMD_MAX) begin
                ovf_next = 1'b1;
            end else begin
                buf_next[len_reg] = cmdByte;
                len_next = len_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_reg <= '{default: 8'h00};
            len_reg <= 3'h0;
            ovf_reg <= 1'b0;
            restore_reg <= 1'b1;
            upSrc_reg <= SRC_COUNT;
            upCh_reg <= `LVS_RST_UPPER_CH;
            lowSrc_reg <= SRC_TIMER;
            lowCh_reg <= `LVS_RST_LOWER_CH;
            light_reg <= `LVS_RST_BACKLIGHT;
            done_reg <= 1'b0;
            bad_reg <= 1'b0;
            store_reg <= 1'b0;
        end else begin
            buf_reg <= buf_next;
            len_reg <= len_next;
            ovf_reg <= ovf_next;
            restore_reg <= restore_next;
            upSrc_reg <= upSrc_next;
            upCh_reg <= upCh_next;
            lowSrc_reg <= lowSrc_next;
            lowCh_reg <= lowCh_next;
            light_reg <= light_next;
            done_reg <= done_next;
            bad_reg <= bad_next;
            store_reg <= store_next;
        end
    end

    assign cmdReady = !restore_reg;
    assign cmdDone = done_reg;
    assign cmdBad = bad_reg;
    assign nvLoadReq = restore_reg;
    assign nvStore = store_reg;
    assign nvStoreData = {light_reg, lowSrc_reg, lowCh_reg, upSrc_reg, upCh_reg};
    assign backlightOn = light_reg;

    // display refresh engine
    lvs_state_t state_reg, state_next;
    logic row_reg, row_next;
    lvs_src_t curSrc_reg, curSrc_next;
    logic [5:0] curCh_reg, curCh_next;
    logic [4:0] col_reg, col_next;
    logic [5:0] step_reg, step_next;
    logic [39:0] bin_reg, bin_next;
    logic [51:0] bcd_reg, bcd_next;
    logic cv_reg, cv_next, cr_reg, cr_next;
    logic [3:0] cc_reg, cc_next;
    logic [7:0] code_reg, code_next;

    always_comb begin
        logic [51:0] adj;
        adj = dabble(bcd_reg);
        state_next = state_reg;
        row_next = row_reg;
        curSrc_next = curSrc_reg;
        curCh_next = curCh_reg;
        col_next = col_reg;
        step_next = step_reg;
        bin_next = bin_reg;
        bcd_next = bcd_reg;
        cv_next = cv_reg;
        cr_next = cr_reg;
        cc_next = cc_reg;
        code_next = code_reg;
        case (state_reg)
            ST_SETUP: begin
                curSrc_next = row_reg ? lowSrc_reg : upSrc_reg;
                curCh_next = row_reg ? lowCh_reg : upCh_reg;
                state_next = ST_LATCH;
            end
            ST_LATCH: begin
                case (curSrc_reg)
                    SRC_COUNT: bin_next = {8'h00, countValue};
                    SRC_TIMER: bin_next = timerValue;
                    SRC_PCOUNT: bin_next = {8'h00, presetCount};
                    default: bin_next = timerPreset;
                endcase
                bcd_next = 52'h0;
                step_next = 6'h00;
                state_next = ST_CONVERT;
            end
            ST_CONVERT: begin
                bcd_next = {adj[50:0], bin_reg[39]};
                bin_next = {bin_reg[38:0], 1'b0};
                step_next = step_reg + 6'h01;
                if (step_reg == `LVS_CONV_LAST) begin
                    col_next = 5'h00;
                    state_next = ST_EMIT;
                end
            end
            ST_EMIT: begin
                if (!cv_reg || charReady) begin
                    if (col_reg == `LVS_ROW_CHARS) begin
                        cv_next = 1'b0;
                        row_next = !row_reg;
                        state_next = ST_SETUP;
                    end else begin
                        cv_next = 1'b1;
                        cr_next = row_reg;
                        cc_next = col_reg[3:0];
                        code_next = charAt(col_reg[3:0], curSrc_reg, curCh_reg, bcd_reg);
                        col_next = col_reg + 5'h01;
                    end
                end
            end
            default: state_next = ST_SETUP;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_SETUP;
            row_reg <= 1'b0;
            curSrc_reg <= SRC_COUNT;
            curCh_reg <= 6'h00;
            col_reg <= 5'h00;
            step_reg <= 6'h00;
            bin_reg <= 40'h0;
            bcd_reg <= 52'h0;
            cv_reg <= 1'b0;
            cr_reg <= 1'b0;
            cc_reg <= 4'h0;
            code_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            row_reg <= row_next;
            curSrc_reg <= curSrc_next;
            curCh_reg <= curCh_next;
            col_reg <= col_next;
            step_reg <= step_next;
            bin_reg <= bin_next;
            bcd_reg <= bcd_next;
            cv_reg <= cv_next;
            cr_reg <= cr_next;
            cc_reg <= cc_next;
            code_reg <= code_next;
        end
    end

    assign chanAddr = curCh_reg;
    assign charValid = cv_reg;
    assign charRow = cr_reg;
    assign charCol = cc_reg;
    assign charCode = code_reg;

endmodule
`default_nettype wire

// *** tb/lvs_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lvs_host_model (
    input wire logic sys_clk,
    input wire logic cmdReady,
    output logic cmdValid,
    output logic [7:0] cmdByte
);
    initial begin
        cmdValid = 1'b0;
        cmdByte = 8'h00;
    end
    // one command line, bytes back to back, held until taken
    task automatic send(input string s);
        logic [7:0] b;
        for (int i = 0; i <= s.len(); i++) begin
            b = (i == s.len()) ? 8'h0d : s.getc(i);
            cmdValid <= 1'b1;
            cmdByte <= b;
            @(posedge sys_clk);
            while (!cmdReady) @(posedge sys_clk);
        end
        cmdValid <= 1'b0;
        cmdByte <= ~b;
    endtask
endmodule
`default_nettype wire

// *** tb/lvs_view_select_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lvs_params.svh"
module lvs_view_props (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cmdReady,
    input wire logic cmdDone,
    input wire logic cmdBad,
    input wire logic nvLoadReq,
    input wire logic nvLoadDone,
    input wire logic [`LVS_NV_BITS-1:0] nvLoadData,
    input wire logic nvStore,
    input wire logic [`LVS_NV_BITS-1:0] nvStoreData,
    input wire logic charValid,
    input wire logic charReady,
    input wire logic charRow,
    input wire logic [3:0] charCol,
    input wire logic [7:0] charCode,
    input wire logic backlightOn
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence taken_s; charValid && charReady; endsequence
    sequence gap_s; !charValid [*8]; endsequence
    col_step_a: assert property (taken_s ##0 charCol != 4'hf |=> charValid && charCol == $past(charCol) + 4'h1 && $stable(charRow)) else $error("column did not advance");
    row_gap_a: assert property (taken_s ##0 charCol == 4'hf |=> gap_s) else $error("no gap after row end");
    stall_hold_a: assert property (charValid && !charReady |=> charValid && $stable(charCode) && $stable(charCol)) else $error("char not held");
    last_space_a: assert property (charValid && charCol == 4'hf |-> charCode == 8'h20) else $error("col 15 not space");
    label_start_a: assert property (charValid && charCol == 4'h0 |-> charCode == 8'h43 || charCode == 8'h54) else $error("bad label");
    nv_load_a: assert property (nvLoadReq && nvLoadDone |=> !nvLoadReq && cmdReady && nvStoreData == $past(nvLoadData)) else $error("load failed");
    load_gate_a: assert property (nvLoadReq |-> !cmdReady) else $error("ready before load");
    store_done_a: assert property (nvStore == cmdDone) else $error("store not with done");
    done_bad_a: assert property (!(cmdDone && cmdBad)) else $error("done and bad together");
    bad_keep_a: assert property (cmdBad |-> $stable(nvStoreData)) else $error("bad command changed setting");
    light_cmd_a: assert property ($changed(backlightOn) && !$past(nvLoadReq) |-> cmdDone && backlightOn == nvStoreData[16]) else $error("light change without command");
endmodule
bind lvs_lcd_view_select lvs_view_props chk_i(.sys_clk, .rst_n, .cmdReady, .cmdDone, .cmdBad, .nvLoadReq, .nvLoadDone,
    .nvLoadData, .nvStore, .nvStoreData, .charValid, .charReady, .charRow, .charCol, .charCode, .backlightOn);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk, rst_n, cmdValid, cmdReady, cmdDone, cmdBad, nvLoadReq, nvLoadDone, nvStore;
    logic charValid, charReady, charRow, backlightOn;
    logic [7:0] cmdByte, charCode;
    logic [16:0] nvLoadData, nvStoreData, cfg;
    logic [5:0] chanAddr;
    logic [3:0] charCol;
    logic [31:0] countValue, presetCount;
    logic [39:0] timerValue, timerPreset;
    logic [7:0] rb [16];
    int fails, n_compared, cyc, seed, r;
    // first ten lines are valid, the rest must be refused
    string cmdHead [15] = '{"SDU", "SDL", "SDU", "SDL", "SDL", "SDU", "BK", "SDL",
        "SDU", "BK", "SDU", "SDU", "BK", "sdu", "SDX"};
    string cmdTail [15] = '{"37", "TM", "CP", "TP", "63", "TM", "OFF", "CP", "TP", "ON", "64", "T", "OFFX", "tm", "12"};
    assign countValue = 32'hffffffc0 | {26'h0, chanAddr};
    lvs_host_model host_i(.sys_clk, .cmdReady, .cmdValid, .cmdByte);
    lvs_lcd_view_select lvs_lcd_view_select_i(.sys_clk, .rst_n, .cmdValid, .cmdByte, .cmdReady, .cmdDone, .cmdBad,
        .nvLoadReq, .nvLoadDone, .nvLoadData, .nvStore, .nvStoreData, .chanAddr, .countValue, .presetCount,
        .timerValue, .timerPreset, .charValid, .charReady, .charRow, .charCol, .charCode, .backlightOn);
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        charReady <= ($random(seed) & 3) != 0;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [16:0] apply(input logic [16:0] c, input string s);
        int o;
        logic [1:0] src;
        o = (s.getc(2) == "L") ? 8 : 0;
        if (s.getc(0) == "B") c[16] = (s.len() == 4);
        else begin
            src = (s.substr(3, 4) == "TM") ? 2'd1 : (s.substr(3, 4) == "CP") ? 2'd2 : (s.substr(3, 4) == "TP") ? 2'd3 : 2'd0;
            c[o+6 +: 2] = src;
            if (src == 2'd0) c[o +: 6] = 6'((s.getc(3) - 48) * 10 + s.getc(4) - 48);
        end
        return c;
    endfunction
    function automatic string exp_row(input logic [16:0] c, input logic row);
        logic [1:0] s;
        logic [5:0] ch;
        logic [39:0] t;
        s = row ? c[15:14] : c[7:6];
        ch = row ? c[13:8] : c[5:0];
        t = (s == 2'd1) ? timerValue : timerPreset;
        if (s == 2'd0) return $sformatf("CNT%02d%010d ", ch, 32'hffffffc0 | {26'h0, ch});
        if (s == 2'd2) return $sformatf("CNTPR%010d ", presetCount);
        return $sformatf("%s%07d.%02d ", (s == 2'd1) ? "TIMER" : "TIMPR", (t / 1000000) % 10000000, (t % 1000000) / 10000);
    endfunction
    // second capture of a row, so the new selection is latched
    task automatic grab(input logic row);
        int k;
        string e;
        for (int p = 0; p < 2; p++) begin
            k = 0;
            for (int n = 0; n < 3000 && k < 16; n++) begin
                @(negedge sys_clk);
                if (charValid && charReady && charRow === row && (k > 0 || charCol === 4'h0)) begin
                    rb[k] = charCode;
                    k++;
                end
            end
        end
        e = exp_row(cfg, row);
        for (int i = 0; i < 16; i++) chk("row char", rb[i], e.getc(i));
    endtask
    task automatic chk_cfg();
        chk("light", backlightOn, cfg[16]);
        chk("saved light", nvStoreData[16], cfg[16]);
        chk("upper src", nvStoreData[7:6], cfg[7:6]);
        chk("lower src", nvStoreData[15:14], cfg[15:14]);
        if (cfg[7:6] == 2'd0) chk("upper ch", nvStoreData[5:0], cfg[5:0]);
        if (cfg[15:14] == 2'd0) chk("lower ch", nvStoreData[13:8], cfg[13:8]);
    endtask
    task automatic run(input string s, input logic good);
        host_i.send(s);
        @(negedge sys_clk);
        chk("done", cmdDone, good);
        chk("bad", cmdBad, !good);
        chk("store", nvStore, good);
        if (good) cfg = apply(cfg, s);
        chk_cfg();
    endtask
    // reset, then storage hands back the saved settings
    task automatic restart(input logic [16:0] saved);
        rst_n <= 1'b0;
        nvLoadDone <= 1'b0;
        nvLoadData <= saved;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("ready early", cmdReady, 1'b0);
        @(posedge sys_clk);
        nvLoadDone <= 1'b1;
        @(posedge sys_clk);
        nvLoadDone <= 1'b0;
        cfg = saved;
        @(negedge sys_clk);
        chk("ready", cmdReady, 1'b1);
        chk_cfg();
    endtask
    // fresh preset count and timer values for every command; counts follow the channel
    task automatic do_cmd(input string s, input logic good);
        @(posedge sys_clk);
        presetCount <= $random(seed);
        timerValue <= 40'({$random(seed), $random(seed)});
        timerPreset <= 40'({$random(seed), $random(seed)});
        run(s, good);
        if (good && s.getc(0) == "S") grab(s.getc(2) == "L");
    endtask
    initial begin
        seed = 32'h22a5;
        fails = 0;
        n_compared = 0;
        presetCount <= $random(seed);
        timerValue <= 40'({$random(seed), $random(seed)});
        timerPreset <= 40'({$random(seed), $random(seed)});
        restart(17'($random(seed)));
        for (int i = 0; i < 15; i++) begin
            do_cmd({cmdHead[i], cmdTail[i]}, i < 10);
        end
        // random channels, those above 63 refused
        repeat (8) begin
            r = $random(seed);
            do_cmd({cmdHead[r[0]], $sformatf("%02d", r[7:1] % 100)}, r[7:1] % 100 < 64);
        end
        // power cycle in mid-run: last saved settings come back
        @(posedge sys_clk);
        restart(cfg);
        grab(1'b0);
        grab(1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
